// [test/hmsd_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module hmsd_sva #(parameter int unsigned CHANNELS = 6) (
  input wire logic                sys_clk,
  input wire logic                rstn,
  input wire logic                ff_clk,
  input wire logic                ff_reset,
  input wire logic [CHANNELS-1:0] ff_d,
  input wire logic [CHANNELS-1:0] ff_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_load; $rose(ff_clk) |-> ##3 ff_q == $past(ff_d, 3); endproperty
  property p_hold; (!ff_clk && !ff_reset) [*4] |-> $stable(ff_q); endproperty
  property p_clr; (ff_reset && !ff_clk) [*5] |-> ff_q == '0; endproperty
  property p_rst; disable iff (1'b0) !rstn |=> ff_q == '0; endproperty
  property p_hi_hold; (ff_clk && !ff_reset) [*5] |-> $stable(ff_q); endproperty
  property p_hi_noclr; (ff_clk && ff_reset) [*5] |-> $stable(ff_q); endproperty
  a_load: assert property (p_load) else $error("load mismatch");
  a_hold: assert property (p_hold) else $error("output moved");
  a_clr: assert property (p_clr) else $error("clear missed");
  a_rst: assert property (p_rst) else $error("reset did not clear");
  a_hi_hold: assert property (p_hi_hold) else $error("output moved while clock high");
  a_hi_noclr: assert property (p_hi_noclr) else $error("clear acted while clock high");
  c_load: cover property ($rose(ff_clk));
  c_clr: cover property (ff_reset && !ff_clk);
  c_hi: cover property (ff_reset && ff_clk);
endmodule
bind hmsd_top hmsd_sva #(.CHANNELS(CHANNELS)) u_hmsd_sva (.sys_clk(sys_clk), .rstn(rstn),
  .ff_clk(ff_clk), .ff_reset(ff_reset), .ff_d(ff_d), .ff_q(ff_q));
`default_nettype wire

// [test/hmsd_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module hmsd_top_tb;
  logic       sys_clk = 0, rstn = 0, ff_clk = 0, ff_reset = 0;
  logic [5:0] ff_d = '0, ff_q;
  int         err_count = 0, compares = 0;
  hmsd_top u_hmsd_top (.sys_clk(sys_clk), .rstn(rstn), .ff_clk(ff_clk), .ff_reset(ff_reset),
    .ff_d(ff_d), .ff_q(ff_q));
  always #20 sys_clk = ~sys_clk;
  task automatic w(int n); repeat (n) @(negedge sys_clk); endtask
  task automatic check(logic [5:0] e);
    compares++;
    if (ff_q !== e) begin
      err_count++;
      $display("unexpected at %0t: q %h not %h", $time, ff_q, e);
    end
  endtask
  // data flipped while clock high must not reach q
  task automatic clk_in(logic [5:0] d);
    ff_d = d; w(3); ff_clk = 1; w(2); ff_d = ~d; w(4); ff_clk = 0; w(4);
  endtask
  task automatic t_load;
    logic [5:0] pat [4] = '{6'h15, 6'h2A, 6'h3F, 6'h00};
    foreach (pat[i]) begin
      clk_in(pat[i]);
      check(pat[i]);
    end
    $display("load test done");
  endtask
  task automatic t_reset;
    ff_d = 6'h3F; w(3); ff_clk = 1; w(2); ff_reset = 1; w(4);
    check(6'h3F);
    ff_clk = 0; w(6);
    check(6'h00);
    ff_reset = 0; w(2);
    $display("reset test done");
  endtask
  // reset held across a rising clock must not block the load
  task automatic t_load_in_reset;
    clk_in(6'h15);
    ff_reset = 1; w(6);
    check(6'h00);
    ff_d = 6'h2A; w(4); ff_clk = 1; w(5);
    check(6'h2A);
    ff_clk = 0; w(6);
    check(6'h00);
    ff_reset = 0; w(2);
    $display("load in reset test done");
  endtask
  task automatic t_rstn;
    clk_in(6'h3F);
    rstn = 0; w(3);
    check(6'h00);
    rstn = 1; w(1);
    clk_in(6'h15);
    check(6'h15);
    $display("mid-run reset test done");
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    w(8); rstn = 1; w(1);
    t_load;
    t_reset;
    t_load_in_reset;
    t_rstn;
    final_report;
  end
  initial begin
    #20us;
    err_count++;
    final_report;
  end
endmodule
`default_nettype wire

// [verilog/hmsd_pkg.sv]
package hmsd_pkg;
  localparam int unsigned CHANNELS      = 6;
  localparam logic        Q_RESET_VALUE = 1'h0;
  localparam logic        CLK_RESET_VAL = 1'h0;
  localparam logic        RST_RESET_VAL = 1'h0;
endpackage

// [verilog/hmsd_slave.sv]
`timescale 1ns/1ps
`default_nettype none
module hmsd_slave (
  input  wire logic   sys_clk,
  input  wire logic   rstn,
  hmsd_stage_if.slave st
);
  logic [$bits(st.q)-1:0] q_r;
  logic [$bits(st.q)-1:0] q_nxt;

  always_comb begin
    q_nxt = q_r;
    if (st.load) begin
      q_nxt = st.master;
    end else if (st.clear) begin
      q_nxt = {$bits(st.q){hmsd_pkg::Q_RESET_VALUE}};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      q_r <= {$bits(st.q){hmsd_pkg::Q_RESET_VALUE}};
    end else begin
      q_r <= q_nxt;
    end
  end

  assign st.q = q_r;
endmodule
`default_nettype wire

// [verilog/hmsd_stage_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface hmsd_stage_if #(
  parameter int unsigned WIDTH = 6
);
  logic [WIDTH-1:0] master;
  logic             load;
  logic             clear;
  logic [WIDTH-1:0] q;
  modport ctrl (output master, output load, output clear, input q);
  modport slave (input master, input load, input clear, output q);
endinterface
`default_nettype wire

// [verilog/hmsd_top.sv]
// Contract
// - six independent master-slave data flip-flops, own data input and output each.
// - one shared clock input and one shared reset input for all six.
// - while clock low, master follows data; output unaffected.
// - on rising clock edge, master value moves to slave output.
// - outputs change only on rising clock edge or when high reset clears them while clock low.
// - reset low, rising edge loads data into output; high gives high.
// - high reset clears outputs only while clock low; never overrides load.
`timescale 1ns/1ps
`default_nettype none
module hmsd_top #(
  parameter int unsigned CHANNELS = hmsd_pkg::CHANNELS
) (
  input  wire logic                sys_clk,
  input  wire logic                rstn,
  input  wire logic                ff_clk,
  input  wire logic                ff_reset,
  input  wire logic [CHANNELS-1:0] ff_d,
  output logic      [CHANNELS-1:0] ff_q
);
  // ff_clk, ff_reset and ff_d are asynchronous to sys_clk, so each passes two flops
  // before any logic reads it; this costs two cycles of latency
  // but keeps metastability away from the edge detector

  // true while the device clock sits in its transparent low phase
  function automatic logic f_low_phase(
    input logic clk_lvl
  );
    f_low_phase = ~clk_lvl;
  endfunction

  // one-cycle pulse on a synchronised low-to-high change
  function automatic logic f_rise(
    input logic cur_lvl,
    input logic prev_lvl
  );
    f_rise = cur_lvl & ~prev_lvl;
  endfunction

  // data pin synchroniser
  logic [CHANNELS-1:0] d_meta_r;
  logic [CHANNELS-1:0] d_meta_nxt;
  logic [CHANNELS-1:0] d_sync_r;
  logic [CHANNELS-1:0] d_sync_nxt;

  // device clock synchroniser and edge history
  logic                clk_meta_r;
  logic                clk_meta_nxt;
  logic                clk_sync_r;
  logic                clk_sync_nxt;
  logic                clk_prev_r;
  logic                clk_prev_nxt;

  // device reset synchroniser
  logic                rst_meta_r;
  logic                rst_meta_nxt;
  logic                rst_sync_r;
  logic                rst_sync_nxt;

  // master stage and decoded strobes
  logic [CHANNELS-1:0] master_r;
  logic [CHANNELS-1:0] master_nxt;
  logic                clk_rise;
  logic                clear_req;

  hmsd_stage_if #(.WIDTH(CHANNELS)) stage ();

  // data group: only the second flop reads the first
  always_comb begin
    d_meta_nxt = ff_d;
    d_sync_nxt = d_meta_r;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      d_meta_r <= {CHANNELS{hmsd_pkg::Q_RESET_VALUE}};
      d_sync_r <= {CHANNELS{hmsd_pkg::Q_RESET_VALUE}};
    end else begin
      d_meta_r <= d_meta_nxt;
      d_sync_r <= d_sync_nxt;
    end
  end

  // clock group: the history flop must reset to the idle level
  // of the pin, otherwise a false edge follows reset release
  always_comb begin
    clk_meta_nxt = ff_clk;
    clk_sync_nxt = clk_meta_r;
    clk_prev_nxt = clk_sync_r;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      clk_meta_r <= hmsd_pkg::CLK_RESET_VAL;
      clk_sync_r <= hmsd_pkg::CLK_RESET_VAL;
      clk_prev_r <= hmsd_pkg::CLK_RESET_VAL;
    end else begin
      clk_meta_r <= clk_meta_nxt;
      clk_sync_r <= clk_sync_nxt;
      clk_prev_r <= clk_prev_nxt;
    end
  end

  // reset group
  always_comb begin
    rst_meta_nxt = ff_reset;
    rst_sync_nxt = rst_meta_r;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rst_meta_r <= hmsd_pkg::RST_RESET_VAL;
      rst_sync_r <= hmsd_pkg::RST_RESET_VAL;
    end else begin
      rst_meta_r <= rst_meta_nxt;
      rst_sync_r <= rst_sync_nxt;
    end
  end

  // master follows data in low phase
  // each channel is its own latch, no bit reads another;
  // the value kept is the last one seen before the edge
  always_comb begin
    master_nxt = master_r;
    for (int i = 0; i < CHANNELS; i++) begin
      if (f_low_phase(clk_sync_r)) begin
        master_nxt[i] = d_sync_r[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      master_r <= {CHANNELS{hmsd_pkg::Q_RESET_VALUE}};
    end else begin
      master_r <= master_nxt;
    end
  end

  always_comb begin
    clk_rise  = f_rise(clk_sync_r, clk_prev_r);
    // clear only in low phase
    // the load strobe and the clear can never meet: one needs
    // the synchronised clock high, the other needs it low
    clear_req = rst_sync_r & f_low_phase(clk_sync_r);
  end

  assign stage.load   = clk_rise;
  assign stage.master = master_r;
  // clear gated by low clock; load wins in slave
  assign stage.clear  = clear_req;

  hmsd_slave u_slave (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .st      (stage.slave)
  );

  assign ff_q = stage.q;
endmodule
`default_nettype wire
